// ---- rtl/ocd_top.sv ----
// Purpose: Decode the oscillator configuration word and run the pin-select lock.
// Assumes: APB slave at 20 MHz on pclk; presetn asynchronous, active low.
// Notes: The word is latched one cycle after reset release and held until the next reset.
// Notes: Register writes take effect on the access edge, where the master sees pready.
// Notes: Programming the cell shows in the decoded word only after the next reset.
// Notes on behaviour
// - Configuration bits are program-once, readable, and read as one when unprogrammed.
// - Switch/monitor field: 1x both off, 01 switching only, 00 both on.
// - One-shot lock set: pin lock may be set once, never cleared, needs unlock.
// - One-shot lock clear: pin lock set and cleared freely, each needing unlock.
// - PLL source select matters only when PLL is not in the system clock.
// - PLL source bit 1 selects primary oscillator, 0 selects fast RC.
// - Secondary select 1 is two-pin crystal, 0 is external digital clock.
// - Clock output drives pin only if enabled and primary is off or external.
// - Primary mode 11 off, 10 high-speed, 01 mid-range, 00 external clock.
//
// The APB register port and the register addresses are this design's own decisions.
`include "ocd_map.svh"
module ocd_top (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`OCD_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Clock system status.
   input wire logic pll_in_sysclk,
   // Decoded oscillator settings.
   output ocd_pkg::ocd_posc_e primary_osc_mode,
   output logic secondary_osc_select,
   output logic pll_source_select,
   output logic pll_feed_primary,
   output logic clock_out_enable,
   output logic clock_output_on_pin,
   output logic clock_switch_enable,
   output logic fail_safe_monitor_enable,
   output logic pin_lock_one_shot,
   output logic pin_select_lock
);
   import ocd_pkg::*;

   // Stored word from the program-once cell.
   ocd_word_t otp_word;
   logic otp_done;
   logic prog_go;
   ocd_otp_cell u_otp (
      .pclk(pclk),
      .prog_en(prog_go),
      .prog_data(pwdata[`OCD_CFG_W-1:0]),
      .rd_data(otp_word),
      .programmed(otp_done)
   );

   // Latched copy of the word; loaded once after reset.
   ocd_word_t cfg_q;
   logic loaded_q;
   ocd_unl_e unl_q;
   logic lock_q;
   logic lock_once_q;
   logic [31:0] rdata_q;
   logic err_q;

   // Bus decode, all in named wires.
   wire setup_ph = psel && !penable;
   wire access_ph = psel && penable;
   wire hit_cfg = (paddr == `OCD_OFS_CFG_WORD);
   wire hit_stat = (paddr == `OCD_OFS_STATUS);
   wire hit_lock = (paddr == `OCD_OFS_LOCK_CTRL);
   wire hit_prog = (paddr == `OCD_OFS_PROGRAM);
   wire hit_any = hit_cfg || hit_stat || hit_lock || hit_prog;
   // Writes land on the access edge, the one edge at which the master sees pready,
   // so a write effect and the bus answer always belong to the same transfer.
   wire wr_done = access_ph && pready && pwrite;
   wire wr_lock = wr_done && hit_lock;
   wire wr_prog = wr_done && hit_prog;
   wire bad_acc = !hit_any || (pwrite && (hit_cfg || hit_stat));

   // Programming needs the top data byte at zero and happens once only.
   assign prog_go = wr_prog && (pwdata[31:`OCD_CFG_W] == 8'h00) && !otp_done;

   // Field decoding from the latched word.
   wire [1:0] fcsm_f = cfg_q[`OCD_FLD_FCSM_HI:`OCD_FLD_FCSM_LO];
   wire [1:0] posc_f = cfg_q[`OCD_FLD_POSC_HI:`OCD_FLD_POSC_LO];
   wire sw_en_d = !fcsm_f[1];
   wire fscm_en_d = (fcsm_f == 2'b00);
   wire posc_off_or_ext = (posc_f == OCD_POSC_OFF) || (posc_f == OCD_POSC_EXT);
   wire ckout_d = cfg_q[`OCD_FLD_CKOE] && posc_off_or_ext;
   wire one_shot = cfg_q[`OCD_FLD_PL1W];

   // Unlock sequence: two key writes open a one-write window.
   wire key1 = wr_lock && (pwdata == `OCD_UNLOCK_KEY1);
   wire key2 = wr_lock && (pwdata == `OCD_UNLOCK_KEY2);
   wire lock_req = wr_lock && (unl_q == OCD_UNL_OPEN);
   wire lock_val = pwdata[`OCD_LOCK_BIT];
   // Once set under one-shot, clears are dropped.
   wire lock_clr_ok = !(one_shot && lock_once_q);
   wire lock_d = lock_req ? (lock_val ? 1'b1 : (lock_clr_ok ? 1'b0 : lock_q)) : lock_q;

   // Reads show the word with upper bits forced high.
   function automatic logic [31:0] rd_mux(input logic [`OCD_ADDR_W-1:0] a);
      if (a == `OCD_OFS_CFG_WORD)
         rd_mux = {8'h00, cfg_q | `OCD_CFG_UNIMPL};
      else if (a == `OCD_OFS_STATUS)
         rd_mux = {29'h00000000, otp_done, loaded_q, lock_q};
      else if (a == `OCD_OFS_LOCK_CTRL)
         rd_mux = {30'h00000000, (unl_q == OCD_UNL_OPEN), lock_q};
      else
         rd_mux = `OCD_ZERO32;
   endfunction

   // Word latch at reset release; held until the next reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= `OCD_CFG_ERASED;
         loaded_q <= 1'b0;
      end else if (!loaded_q) begin
         cfg_q <= otp_word | `OCD_CFG_UNIMPL;
         loaded_q <= 1'b1;
      end
   end

   // Unlock state machine; any other lock write closes the window.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unl_q <= OCD_UNL_IDLE;
      end else if (wr_lock) begin
         case (unl_q)
            OCD_UNL_IDLE: unl_q <= key1 ? OCD_UNL_KEY1 : OCD_UNL_IDLE;
            OCD_UNL_KEY1: unl_q <= key2 ? OCD_UNL_OPEN : OCD_UNL_IDLE;
            OCD_UNL_OPEN: unl_q <= OCD_UNL_IDLE;
            default: unl_q <= OCD_UNL_IDLE;
         endcase
      end
   end

   // Pin-select lock and its once-set memory.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_q <= 1'b0;
         lock_once_q <= 1'b0;
      end else begin
         lock_q <= lock_d;
         lock_once_q <= lock_once_q || (lock_req && lock_val);
      end
   end

   // APB answer: no wait state, registered data and error.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         rdata_q <= `OCD_ZERO32;
         err_q <= 1'b0;
      end else begin
         pready <= setup_ph;
         rdata_q <= setup_ph ? rd_mux(paddr) : `OCD_ZERO32;
         err_q <= setup_ph && bad_acc;
      end
   end
   assign prdata = rdata_q;
   // The error flop only rises with pready, so it drives the pin directly.
   assign pslverr = err_q;

   // Decoded settings registered onto the outputs.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         primary_osc_mode <= OCD_POSC_OFF;
         secondary_osc_select <= 1'b1;
         pll_source_select <= 1'b1;
         pll_feed_primary <= 1'b1;
         clock_out_enable <= 1'b0;
         clock_output_on_pin <= 1'b0;
         clock_switch_enable <= 1'b0;
         fail_safe_monitor_enable <= 1'b0;
         pin_lock_one_shot <= 1'b1;
         pin_select_lock <= 1'b0;
      end else begin
         primary_osc_mode <= ocd_posc_e'(posc_f);
         secondary_osc_select <= cfg_q[`OCD_FLD_SOSC];
         pll_source_select <= cfg_q[`OCD_FLD_PLLSRC];
         // Source applies only when the PLL is free of the system clock.
         pll_feed_primary <= pll_in_sysclk ? pll_feed_primary : cfg_q[`OCD_FLD_PLLSRC];
         clock_out_enable <= cfg_q[`OCD_FLD_CKOE];
         clock_output_on_pin <= ckout_d;
         clock_switch_enable <= sw_en_d;
         fail_safe_monitor_enable <= fscm_en_d;
         pin_lock_one_shot <= one_shot;
         pin_select_lock <= lock_q;
      end
   end

   // Checks.
   a_word_held: assert property (@(posedge pclk) disable iff (!presetn)
      loaded_q && $past(loaded_q) |-> $stable(cfg_q))
      else $error("config word changed after load");
   a_upper_ones: assert property (@(posedge pclk) disable iff (!presetn)
      loaded_q |-> (cfg_q & `OCD_CFG_UNIMPL) == `OCD_CFG_UNIMPL)
      else $error("unimplemented bits not one");
   a_fcsm_dec: assert property (@(posedge pclk) disable iff (!presetn)
      $past(loaded_q) |-> clock_switch_enable == !$past(fcsm_f[1])
      && fail_safe_monitor_enable == ($past(fcsm_f) == 2'b00))
      else $error("switch monitor decode wrong");
   a_posc_dec: assert property (@(posedge pclk) disable iff (!presetn)
      $past(loaded_q) |-> primary_osc_mode == $past(posc_f))
      else $error("primary mode decode wrong");
   a_ckout_gate: assert property (@(posedge pclk) disable iff (!presetn)
      clock_output_on_pin |-> clock_out_enable
      && (primary_osc_mode == OCD_POSC_OFF || primary_osc_mode == OCD_POSC_EXT))
      else $error("clock output driven in crystal mode");
   a_sosc_dec: assert property (@(posedge pclk) disable iff (!presetn)
      $past(loaded_q) |-> secondary_osc_select == $past(cfg_q[`OCD_FLD_SOSC]))
      else $error("secondary select wrong");
   a_pll_src: assert property (@(posedge pclk) disable iff (!presetn)
      $past(loaded_q) && !$past(pll_in_sysclk)
      |-> pll_feed_primary == $past(cfg_q[`OCD_FLD_PLLSRC]))
      else $error("pll feed wrong");
   a_pll_hold: assert property (@(posedge pclk) disable iff (!presetn)
      $past(pll_in_sysclk) |-> $stable(pll_feed_primary))
      else $error("pll feed moved while in system clock");
   a_lock_oneway: assert property (@(posedge pclk) disable iff (!presetn)
      one_shot && lock_once_q |-> ##1 lock_q)
      else $error("one-shot lock cleared");
   a_lock_gated: assert property (@(posedge pclk) disable iff (!presetn)
      lock_q != $past(lock_q) |-> $past(unl_q) == OCD_UNL_OPEN)
      else $error("lock changed without unlock");
   a_prog_once: assert property (@(posedge pclk)
      otp_done |=> otp_done)
      else $error("program-once flag dropped");

   // Once the cell holds a word, no further program strobe may reach it.
   a_prog_blocked: assert property (@(posedge pclk) disable iff (!presetn)
      otp_done |-> !prog_go)
      else $error("program strobe after the cell was written");

   // Bus answer: pready is a single-cycle pulse that follows a setup cycle.
   a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("pready stood for more than one cycle");

   a_ready_setup: assert property (@(posedge pclk) disable iff (!presetn)
      pready |-> $past(setup_ph))
      else $error("pready without a setup cycle");

   // An error is only shown together with the answer.
   a_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("pslverr without pready");

   // Writes to the read-only word and unmapped offsets are refused.
   a_err_bad: assert property (@(posedge pclk) disable iff (!presetn)
      $past(presetn) && $past(setup_ph && bad_acc) |-> pslverr)
      else $error("bad access not refused");

   // An open window always lets the lock be set.
   a_lock_set: assert property (@(posedge pclk) disable iff (!presetn)
      lock_req && lock_val |=> lock_q)
      else $error("lock set refused inside window");

   // Without the one-shot setting a clear inside the window always works.
   a_lock_clear: assert property (@(posedge pclk) disable iff (!presetn)
      !one_shot && lock_req && !lock_val |=> !lock_q)
      else $error("lock clear refused without one-shot");

   // The pin copy of the lock trails the internal bit by one edge.
   a_lock_pin: assert property (@(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> pin_select_lock == $past(lock_q))
      else $error("pin lock copy wrong");

   // Clock output needs the enable and a primary mode of off or external.
   a_ckout_rule: assert property (@(posedge pclk) disable iff (!presetn)
      $past(loaded_q) |-> clock_output_on_pin == ($past(cfg_q[`OCD_FLD_CKOE])
      && ($past(posc_f) == OCD_POSC_OFF || $past(posc_f) == OCD_POSC_EXT)))
      else $error("clock output gating wrong");

   a_clkoe_raw: assert property (@(posedge pclk) disable iff (!presetn)
      $past(loaded_q) |-> clock_out_enable == $past(cfg_q[`OCD_FLD_CKOE]))
      else $error("clock output enable copy wrong");

   a_src_raw: assert property (@(posedge pclk) disable iff (!presetn)
      $past(loaded_q) |-> pll_source_select == $past(cfg_q[`OCD_FLD_PLLSRC]))
      else $error("pll source copy wrong");

   a_oneshot_out: assert property (@(posedge pclk) disable iff (!presetn)
      $past(loaded_q) |-> pin_lock_one_shot == $past(cfg_q[`OCD_FLD_PL1W]))
      else $error("one-shot setting copy wrong");

   // Scenarios worth seeing at least once.
   c_prog_word: cover property (@(posedge pclk) disable iff (!presetn) $rose(otp_done));
   c_unlock_set: cover property (@(posedge pclk) disable iff (!presetn) $rose(lock_q));
   c_unlock_clr: cover property (@(posedge pclk) disable iff (!presetn) $fell(lock_q));
   c_ckout_on: cover property (@(posedge pclk) disable iff (!presetn) clock_output_on_pin);
   c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule

// ---- rtl/ocd_map.svh ----
// Purpose: Register offsets, field positions and reset values of the oscillator config decoder.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes: Definitions only.
`ifndef OCD_MAP_SVH
`define OCD_MAP_SVH
`define OCD_ADDR_W 12
`define OCD_OFS_CFG_WORD 12'h000
`define OCD_OFS_STATUS 12'h004
`define OCD_OFS_LOCK_CTRL 12'h008
`define OCD_OFS_PROGRAM 12'h00C
`define OCD_CFG_W 24
`define OCD_CFG_ERASED 24'hFFFFFF
`define OCD_CFG_IMPL_MASK 24'h0000FF
`define OCD_CFG_UNIMPL 24'hFFFF00
`define OCD_FLD_FCSM_HI 7
`define OCD_FLD_FCSM_LO 6
`define OCD_FLD_PL1W 5
`define OCD_FLD_PLLSRC 4
`define OCD_FLD_SOSC 3
`define OCD_FLD_CKOE 2
`define OCD_FLD_POSC_HI 1
`define OCD_FLD_POSC_LO 0
`define OCD_UNLOCK_KEY1 32'h000000AA
`define OCD_UNLOCK_KEY2 32'h00000055
`define OCD_LOCK_BIT 0
`define OCD_PROGRAM_KEY 32'h0000C0DE
`define OCD_ZERO32 32'h00000000
`endif

// ---- rtl/ocd_pkg.sv ----
// Purpose: Types shared by the oscillator config decoder files.
// Assumes: Field encodings as in the configuration word.
// Notes: Constants live in ocd_map.svh.
package ocd_pkg;
   typedef enum logic [1:0] {
      OCD_POSC_EXT = 2'b00,
      OCD_POSC_MID = 2'b01,
      OCD_POSC_HS = 2'b10,
      OCD_POSC_OFF = 2'b11
   } ocd_posc_e;
   typedef enum logic [1:0] {
      OCD_UNL_IDLE = 2'b00,
      OCD_UNL_KEY1 = 2'b01,
      OCD_UNL_OPEN = 2'b10
   } ocd_unl_e;
   typedef logic [23:0] ocd_word_t;
endpackage

// ---- rtl/ocd_otp_cell.sv ----
// Purpose: Program-once storage for the oscillator configuration word.
// Assumes: Erased state is all ones; programming can only clear bits.
// Notes: Read data comes out of a register; content survives presetn.
`include "ocd_map.svh"
module ocd_otp_cell (
   // Clock.
   input wire logic pclk,
   // Program port.
   input wire logic prog_en,
   input wire ocd_pkg::ocd_word_t prog_data,
   // Read port.
   output ocd_pkg::ocd_word_t rd_data,
   output logic programmed
);
   import ocd_pkg::*;
   ocd_word_t cell_q = `OCD_CFG_ERASED;
   logic done_q = 1'b0;
   // A cell is written once; later attempts are ignored, as in real fuse arrays.
   always_ff @(posedge pclk) begin
      if (prog_en && !done_q) begin
         cell_q <= (prog_data | `OCD_CFG_UNIMPL) & cell_q;
         done_q <= 1'b1;
      end
   end
   // Registered read data.
   always_ff @(posedge pclk) begin
      rd_data <= cell_q;
      programmed <= done_q;
   end
endmodule

// ---- testbench/ocd_clk_sys_model.sv ----
// Purpose: Model of the clock system beside the decoder, reporting PLL use in the system clock.
// Assumes: Same clock domain as the decoder; changes land after a rising edge.
// Notes: The bench asks for the PLL to join or leave the system clock.
module ocd_clk_sys_model (
   // Clock.
   input wire logic pclk,
   // Request from the bench.
   input wire logic want_pll,
   // Status to the decoder.
   output logic pll_in_sysclk
);
   timeunit 1ns;
   timeprecision 1ns;
   // A real clock switch settles on an edge, so the status is registered.
   initial pll_in_sysclk = 1'b0;
   always @(posedge pclk) begin
      pll_in_sysclk <= want_pll;
   end
endmodule

// ---- testbench/oscillator_config_decode_tb_top.sv ----
// Purpose: Self-checking bench for the oscillator config decoder.
// Assumes: APB answers with pready; the word is programmed once per run.
// Notes: The random byte keeps the one-shot and PLL source bits at zero.
`include "ocd_map.svh"
module oscillator_config_decode_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import ocd_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, want_pll, pll_in_sysclk, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic er;
   ocd_posc_e pmode;
   logic sosc, src, feed, ckoe, ckpin, sw, fscm, oneshot, lock;
   int n_mismatch, tests_run, cyc;
   logic [15:0] seed;
   logic [7:0] v;
   // Design under test.
   ocd_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pll_in_sysclk(pll_in_sysclk), .primary_osc_mode(pmode),
      .secondary_osc_select(sosc), .pll_source_select(src), .pll_feed_primary(feed),
      .clock_out_enable(ckoe), .clock_output_on_pin(ckpin), .clock_switch_enable(sw),
      .fail_safe_monitor_enable(fscm), .pin_lock_one_shot(oneshot), .pin_select_lock(lock));
   ocd_clk_sys_model i_clk_sys (.pclk(pclk), .want_pll(want_pll), .pll_in_sysclk(pll_in_sysclk));
   // Clock at 20 MHz.
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   function automatic logic [15:0] lfsr(logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   // Expected decode of the low byte: mode, sosc, src, clkout enable, pin, switch, monitor, one-shot.
   function automatic logic [8:0] dec(logic [7:0] w);
      return {w[1:0], w[3], w[4], w[2], w[2] & (w[1:0] == 2'b11 || w[1:0] == 2'b00), ~w[7],
         ~w[7] & ~w[6], w[5]};
   endfunction
   task automatic chk_rd(logic [31:0] got, logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(logic [8:0] got, logic [8:0] exp);
      chk_rd({23'h0, got}, {23'h0, exp});
   endtask
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // One APB transfer; the request is held until pready is sampled high.
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic set_lock(logic b);
      apb(1'b1, `OCD_OFS_LOCK_CTRL, `OCD_UNLOCK_KEY1);
      apb(1'b1, `OCD_OFS_LOCK_CTRL, `OCD_UNLOCK_KEY2);
      apb(1'b1, `OCD_OFS_LOCK_CTRL, {31'h0, b});
      repeat (2) @(posedge pclk);
   endtask
   task automatic do_reset();
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
   endtask
   // A hang is cut short here.
   always @(posedge pclk) begin
      cyc++;
      if (cyc > 5000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, want_pll} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      seed = 16'h9CD0;
      do_reset();
      apb(1'b0, `OCD_OFS_CFG_WORD, 32'h0);
      chk_rd(rd, 32'h00FFFFFF);
      chk_pin({pmode, sosc, src, ckoe, ckpin, sw, fscm, oneshot}, dec(8'hFF));
      apb(1'b0, 12'hFF0, 32'h0);
      chk_rd({31'h0, er}, 32'h1);
      apb(1'b1, `OCD_OFS_CFG_WORD, 32'h0);
      chk_rd({31'h0, er}, 32'h1);
      set_lock(1'b1);
      chk_rd({31'h0, lock}, 32'h1);
      set_lock(1'b0);
      chk_rd({31'h0, lock}, 32'h1);
      seed = lfsr(lfsr(seed));
      v = seed[7:0] & 8'hCF;
      apb(1'b1, `OCD_OFS_PROGRAM, {24'h0, v});
      apb(1'b0, `OCD_OFS_CFG_WORD, 32'h0);
      chk_rd(rd, 32'h00FFFFFF);
      want_pll <= 1'b1;
      do_reset();
      chk_rd({31'h0, feed}, 32'h1);
      want_pll <= 1'b0;
      repeat (3) @(posedge pclk);
      chk_rd({31'h0, feed}, 32'h0);
      apb(1'b0, `OCD_OFS_CFG_WORD, 32'h0);
      chk_rd(rd, {16'h00FF, 8'hFF, v});
      chk_pin({pmode, sosc, src, ckoe, ckpin, sw, fscm, oneshot}, dec(v));
      apb(1'b1, `OCD_OFS_PROGRAM, 32'h0);
      do_reset();
      apb(1'b0, `OCD_OFS_CFG_WORD, 32'h0);
      chk_rd(rd, {16'h00FF, 8'hFF, v});
      set_lock(1'b1);
      chk_rd({31'h0, lock}, 32'h1);
      set_lock(1'b0);
      chk_rd({31'h0, lock}, 32'h0);
      apb(1'b1, `OCD_OFS_LOCK_CTRL, 32'h1);
      repeat (2) @(posedge pclk);
      chk_rd({31'h0, lock}, 32'h0);
      give_verdict();
   end
endmodule
